// ==== src/vdm_voltage_distortion_monitor.sv ====
// Three-channel voltage harmonic distortion monitor with alarm timer
// Operation
// R01: Distortion is harmonic power over fundamental power of same channel.
// R02: Track each channel's magnitude and harmonics up to order 31.
// R03: Power ratio: sum of squares of harmonics 2..31 over fundamental squared.
// R04: Amplitude ratio: square root of the power-ratio quotient.
// R05: Every calculation consumes all 32 spectrum components of a channel.
// R06: Three independent channel spectra give three separate results.
// R07: One method selection serves all channels alike.
// R08: Mode and method are static, untouched by setting group changes.
// R09: Five modes, default on, individual mode only when globally allowed.
// R10: Method defaults to amplitude ratio; power ratio is the alternative.
// R11: Alarm raised when distortion rises above user limits.
// R12: Pick-up releases only below 97 percent of the threshold.
// R13: Any channel above shared 0.01 % threshold picks up, if enabled.
// R14: Alarm follows pick-up after definite delay in 5 ms steps.
// R15: Block at pick-up gives blocked; block after start releases start.
// R16: All channels recomputed once per processing cycle from one spectrum.
module vdm_voltage_distortion_monitor #(
  parameter int STEP_CYCLES = vdm_pkg::STEP_CYCLES
) (
  // Clock and reset
  input  wire logic                      CLK_I,
  input  wire logic                      SYS_RST_I,
  // Register port
  input  wire logic [7:0]                ADDR_I,
  input  wire logic [31:0]               WR_DATA_I,
  input  wire logic                      WR_I,
  input  wire logic                      RD_I,
  output logic      [31:0]               RD_DATA_O,
  // Spectrum stream, one component per valid beat
  input  wire logic                      SPEC_VALID_I,
  input  wire logic                      SPEC_FIRST_I,
  input  wire logic [vdm_pkg::MAG_W-1:0] SPEC_CH1_I,
  input  wire logic [vdm_pkg::MAG_W-1:0] SPEC_CH2_I,
  input  wire logic [vdm_pkg::MAG_W-1:0] SPEC_CH3_I,
  // System controls
  input  wire logic                      BLOCK_I,
  input  wire logic                      INDIV_MODE_EN_I,
  // Status
  output logic                           BUSY_O,
  output logic                           START_O,
  output logic                           ALARM_O,
  output logic                           BLOCKED_O,
  output logic                           IRQ_O
);
  localparam int CH = vdm_pkg::CHANNELS;

  function automatic logic [31:0] square(input logic [15:0] m);
    square = m * m;
  endfunction : square

  function automatic logic [31:0] sat32(input logic [63:0] q);
    sat32 = (|q[63:32]) ? 32'hffff_ffff : q[31:0];
  endfunction : sat32

  // Configuration and interrupt group
  logic [2:0]             mode_reg, mode_next;
  logic                   method_reg, method_next;
  logic                   alm_en_reg, alm_en_next;
  logic [13:0]            thr_reg, thr_next;
  logic [18:0]            dly_reg, dly_next;
  logic [vdm_pkg::EV_W-1:0] ist_reg, ist_next;
  logic [vdm_pkg::EV_W-1:0] imask_reg, imask_next;
  logic [31:0]            rd_reg, rd_next;
  logic                   irq_reg, irq_next;
  // Engine group
  vdm_pkg::vdm_phase_t    phase_reg, phase_next;
  vdm_pkg::vdm_cond_t     cond_reg, cond_next;
  logic [4:0]             idx_reg, idx_next;
  logic [31:0]            fund_reg [CH];
  logic [31:0]            fund_next [CH];
  logic [36:0]            harm_reg [CH];
  logic [36:0]            harm_next [CH];
  logic [31:0]            res_reg [CH];
  logic [31:0]            res_next [CH];
  logic [CH-1:0]          pick_reg, pick_next;
  logic [1:0]             ch_reg, ch_next;
  logic [63:0]            num_reg, num_next;
  logic [31:0]            den_reg, den_next;
  logic [32:0]            rem_reg, rem_next;
  logic [63:0]            quo_reg, quo_next;
  logic [63:0]            bit_reg, bit_next;
  logic [6:0]             cnt_reg, cnt_next;
  logic [19:0]            tick_reg, tick_next;
  logic [18:0]            timer_reg, timer_next;
  logic                   busy_reg, busy_next;
  logic                   start_reg, start_next;
  logic                   alarm_reg, alarm_next;
  logic                   blocked_reg, blocked_next;

  logic [2:0]             eff_mode;
  logic [vdm_pkg::EV_W-1:0] ev;
  logic [15:0]            mag [CH];
  logic [32:0]            rem_sh;
  logic [63:0]            trial;
  logic [39:0]            res_scaled;
  logic [39:0]            thr_scaled;
  logic                   blk;
  logic                   any_pick;

  assign mag[0] = SPEC_CH1_I;
  assign mag[1] = SPEC_CH2_I;
  assign mag[2] = SPEC_CH3_I;

  // Individual mode only honoured when globally allowed
  assign eff_mode = INDIV_MODE_EN_I ? mode_reg : vdm_pkg::MODE_ON; // R09
  assign blk = BLOCK_I || eff_mode == vdm_pkg::MODE_BLOCKED
               || eff_mode == vdm_pkg::MODE_TEST_BLOCKED;
  assign any_pick = alm_en_reg && (|pick_reg); // R13

  always_comb begin
    phase_next = phase_reg;
    cond_next  = cond_reg;
    idx_next   = idx_reg;
    fund_next  = fund_reg;
    harm_next  = harm_reg;
    res_next   = res_reg;
    pick_next  = pick_reg;
    ch_next    = ch_reg;
    num_next   = num_reg;
    den_next   = den_reg;
    rem_next   = rem_reg;
    quo_next   = quo_reg;
    bit_next   = bit_reg;
    cnt_next   = cnt_reg;
    timer_next = timer_reg;
    ev         = '0;
    rem_sh     = {rem_reg[31:0], num_reg[63]};
    trial      = quo_reg + bit_reg;
    res_scaled = 40'(res_reg[ch_reg]) * 40'(vdm_pkg::FULL_PCT);
    thr_scaled = 40'(thr_reg) * 40'(vdm_pkg::RELEASE_PCT);
    tick_next  = (tick_reg == 20'(STEP_CYCLES - 1)) ? '0 : tick_reg + 20'h1;
    unique case (phase_reg)
      vdm_pkg::VDM_COLLECT: begin
        // Spectrum is taken whole; a new one only after the last result
        if (SPEC_VALID_I && (SPEC_FIRST_I || idx_reg != '0)) begin
          for (int c = 0; c < CH; c++) begin // R06
            if (SPEC_FIRST_I) begin
              fund_next[c] = square(mag[c]); // R01
              harm_next[c] = '0;
            end else begin
              harm_next[c] = harm_reg[c] + 37'(square(mag[c])); // R03
            end
          end
          idx_next = SPEC_FIRST_I ? 5'h1 : idx_reg + 5'h1;
          // Last of 32 components closes the coherent set
          if (!SPEC_FIRST_I && idx_reg == 5'(vdm_pkg::COMPONENTS - 1)) begin
            idx_next   = '0; // R05 R02
            ch_next    = '0;
            phase_next = vdm_pkg::VDM_EVAL; // R16
            cnt_next   = '1;
          end
        end
      end
      vdm_pkg::VDM_DIV: begin
        if (rem_sh >= {1'b0, den_reg}) begin
          rem_next = rem_sh - {1'b0, den_reg};
          quo_next = {quo_reg[62:0], 1'b1};
        end else begin
          rem_next = rem_sh;
          quo_next = {quo_reg[62:0], 1'b0};
        end
        num_next = {num_reg[62:0], 1'b0};
        cnt_next = cnt_reg + 7'h1;
        if (cnt_reg == 7'(vdm_pkg::DIV_STEPS - 1)) begin
          if (method_reg) begin // R07
            res_next[ch_reg] = sat32(quo_next); // R03
            phase_next = vdm_pkg::VDM_EVAL;
          end else begin
            num_next   = quo_next; // R04
            quo_next   = '0;
            bit_next   = 64'h4000_0000_0000_0000;
            cnt_next   = '0;
            phase_next = vdm_pkg::VDM_SQRT;
          end
        end
      end
      vdm_pkg::VDM_SQRT: begin
        if (num_reg >= trial) begin
          num_next = num_reg - trial;
          quo_next = (quo_reg >> 1) + bit_reg;
        end else begin
          quo_next = quo_reg >> 1;
        end
        bit_next = bit_reg >> 2;
        cnt_next = cnt_reg + 7'h1;
        if (cnt_reg == 7'(vdm_pkg::SQRT_STEPS - 1)) begin
          res_next[ch_reg] = quo_next[31:0]; // R04
          phase_next = vdm_pkg::VDM_EVAL;
        end
      end
      vdm_pkg::VDM_EVAL: begin
        // Entered with all-ones count to start the first channel
        if (cnt_reg != '1) begin
          if (!pick_reg[ch_reg] && res_reg[ch_reg] > 32'(thr_reg)) begin
            pick_next[ch_reg] = 1'b1; // R13
          end else if (pick_reg[ch_reg] && res_scaled < thr_scaled) begin
            pick_next[ch_reg] = 1'b0; // R12
          end
          ch_next = ch_reg + 2'h1;
        end
        if (cnt_reg != '1 && ch_reg == 2'(CH - 1)) begin
          phase_next = vdm_pkg::VDM_DECIDE;
        end else begin
          // Scaled numerator: 37-bit sum times up to 27-bit scale fits 64
          num_next = 64'(harm_next[ch_next]) *
                     (method_reg ? vdm_pkg::POWER_SCALE
                                 : vdm_pkg::AMP_SCALE); // R07
          den_next = fund_next[ch_next];
          rem_next = '0;
          quo_next = '0;
          cnt_next = '0;
          phase_next = vdm_pkg::VDM_DIV;
          if (fund_next[ch_next] == '0) begin
            // No fundamental: report full scale rather than divide by zero
            res_next[ch_next] = 32'hffff_ffff;
            cnt_next = '0;
            ch_next  = ch_next;
            phase_next = vdm_pkg::VDM_EVAL;
          end
        end
      end
      vdm_pkg::VDM_DECIDE: begin
        ev[vdm_pkg::EV_DONE] = 1'b1;
        phase_next = vdm_pkg::VDM_COLLECT;
        unique case (cond_reg)
          vdm_pkg::VDM_NORMAL: begin
            if (any_pick) begin // R11
              cond_next  = blk ? vdm_pkg::VDM_BLOCKED
                               : vdm_pkg::VDM_START; // R15
              timer_next = '0;
            end
          end
          vdm_pkg::VDM_START, vdm_pkg::VDM_ALARM: begin
            if (!any_pick || blk) cond_next = vdm_pkg::VDM_NORMAL; // R15
          end
          vdm_pkg::VDM_BLOCKED: begin
            if (!any_pick) cond_next = vdm_pkg::VDM_NORMAL;
          end
        endcase
      end
    endcase
    // Definite-time delay runs between processing cycles too
    if (cond_reg == vdm_pkg::VDM_START && cond_next == vdm_pkg::VDM_START)
    begin
      if (timer_reg >= dly_reg) begin
        cond_next = vdm_pkg::VDM_ALARM; // R14
      end else if (tick_reg == 20'(STEP_CYCLES - 1)) begin
        timer_next = timer_reg + 19'h1; // R14
      end
    end
    if (eff_mode == vdm_pkg::MODE_OFF) begin
      phase_next = vdm_pkg::VDM_COLLECT;
      cond_next  = vdm_pkg::VDM_NORMAL;
      pick_next  = '0;
      idx_next   = '0;
    end
    ev[vdm_pkg::EV_START] = cond_reg == vdm_pkg::VDM_NORMAL &&
                            cond_next == vdm_pkg::VDM_START;
    ev[vdm_pkg::EV_ALARM] = cond_reg != vdm_pkg::VDM_ALARM &&
                            cond_next == vdm_pkg::VDM_ALARM;
    ev[vdm_pkg::EV_BLOCKED] = cond_reg != vdm_pkg::VDM_BLOCKED &&
                              cond_next == vdm_pkg::VDM_BLOCKED;
    busy_next = phase_next != vdm_pkg::VDM_COLLECT;
    // Test mode keeps start and alarm quiet while status still shows
    start_next = (cond_next == vdm_pkg::VDM_START ||
                  cond_next == vdm_pkg::VDM_ALARM) &&
                 eff_mode != vdm_pkg::MODE_TEST;
    alarm_next = cond_next == vdm_pkg::VDM_ALARM &&
                 eff_mode != vdm_pkg::MODE_TEST;
    blocked_next = cond_next == vdm_pkg::VDM_BLOCKED;
  end

  always_ff @(posedge CLK_I) begin
    if (SYS_RST_I) begin
      phase_reg   <= vdm_pkg::VDM_COLLECT;
      cond_reg    <= vdm_pkg::VDM_NORMAL;
      idx_reg     <= '0;
      fund_reg    <= '{default: '0};
      harm_reg    <= '{default: '0};
      res_reg     <= '{default: '0};
      pick_reg    <= '0;
      ch_reg      <= '0;
      num_reg     <= '0;
      den_reg     <= '0;
      rem_reg     <= '0;
      quo_reg     <= '0;
      bit_reg     <= '0;
      cnt_reg     <= '0;
      tick_reg    <= '0;
      timer_reg   <= '0;
      busy_reg    <= 1'b0;
      start_reg   <= 1'b0;
      alarm_reg   <= 1'b0;
      blocked_reg <= 1'b0;
    end else begin
      phase_reg   <= phase_next;
      cond_reg    <= cond_next;
      idx_reg     <= idx_next;
      fund_reg    <= fund_next;
      harm_reg    <= harm_next;
      res_reg     <= res_next;
      pick_reg    <= pick_next;
      ch_reg      <= ch_next;
      num_reg     <= num_next;
      den_reg     <= den_next;
      rem_reg     <= rem_next;
      quo_reg     <= quo_next;
      bit_reg     <= bit_next;
      cnt_reg     <= cnt_next;
      tick_reg    <= tick_next;
      timer_reg   <= timer_next;
      busy_reg    <= busy_next;
      start_reg   <= start_next;
      alarm_reg   <= alarm_next;
      blocked_reg <= blocked_next;
    end
  end

  // Register access; mode and method live only in CTRL, outside any group
  always_comb begin
    mode_next   = mode_reg;
    method_next = method_reg;
    alm_en_next = alm_en_reg;
    thr_next    = thr_reg;
    dly_next    = dly_reg;
    imask_next  = imask_reg;
    rd_next     = '0;
    ist_next    = ist_reg;
    if (WR_I) begin
      unique case (ADDR_I)
        vdm_pkg::CTRL_OFS: begin
          mode_next   = WR_DATA_I[vdm_pkg::CTRL_MODE_LSB +: 3]; // R08 R09
          method_next = WR_DATA_I[vdm_pkg::CTRL_METHOD]; // R07 R10
          alm_en_next = WR_DATA_I[vdm_pkg::CTRL_ALM_EN];
        end
        vdm_pkg::THRESH_OFS:   thr_next   = WR_DATA_I[13:0];
        vdm_pkg::DELAY_OFS:    dly_next   = WR_DATA_I[18:0];
        vdm_pkg::INT_STAT_OFS: ist_next   = ist_reg & ~WR_DATA_I[3:0];
        vdm_pkg::INT_MASK_OFS: imask_next = WR_DATA_I[3:0];
        default: ;
      endcase
    end
    // Set wins over a clear in the same cycle
    ist_next = ist_next | ev;
    if (RD_I) begin
      unique case (ADDR_I)
        vdm_pkg::CTRL_OFS:     rd_next = {27'h0, alm_en_reg, method_reg,
                                          mode_reg};
        vdm_pkg::THRESH_OFS:   rd_next = {18'h0, thr_reg};
        vdm_pkg::DELAY_OFS:    rd_next = {13'h0, dly_reg};
        vdm_pkg::STATUS_OFS:   rd_next = {26'h0, busy_reg, pick_reg,
                                          cond_reg};
        vdm_pkg::INT_STAT_OFS: rd_next = {28'h0, ist_reg};
        vdm_pkg::INT_MASK_OFS: rd_next = {28'h0, imask_reg};
        vdm_pkg::RESULT1_OFS:  rd_next = res_reg[0];
        vdm_pkg::RESULT2_OFS:  rd_next = res_reg[1];
        vdm_pkg::RESULT3_OFS:  rd_next = res_reg[2];
        default:               rd_next = '0;
      endcase
    end
    irq_next = |(ist_next & imask_next);
  end

  always_ff @(posedge CLK_I) begin
    if (SYS_RST_I) begin
      mode_reg   <= vdm_pkg::MODE_RST;
      method_reg <= vdm_pkg::METHOD_RST;
      alm_en_reg <= vdm_pkg::ALM_EN_RST;
      thr_reg    <= vdm_pkg::THRESH_RST;
      dly_reg    <= vdm_pkg::DELAY_RST;
      ist_reg    <= '0;
      imask_reg  <= '0;
      rd_reg     <= '0;
      irq_reg    <= 1'b0;
    end else begin
      mode_reg   <= mode_next;
      method_reg <= method_next;
      alm_en_reg <= alm_en_next;
      thr_reg    <= thr_next;
      dly_reg    <= dly_next;
      ist_reg    <= ist_next;
      imask_reg  <= imask_next;
      rd_reg     <= rd_next;
      irq_reg    <= irq_next;
    end
  end

  assign RD_DATA_O = rd_reg;
  assign BUSY_O    = busy_reg;
  assign START_O   = start_reg;
  assign ALARM_O   = alarm_reg;
  assign BLOCKED_O = blocked_reg;
  assign IRQ_O     = irq_reg;
endmodule : vdm_voltage_distortion_monitor

// ==== src/vdm_pkg.sv ====
// Constants, register map and types of the voltage distortion monitor
package vdm_pkg;
  // Spectrum shape: fundamental plus harmonics up to order 31
  localparam int COMPONENTS   = 32;
  localparam int CHANNELS     = 3;
  localparam int MAG_W        = 16;
  localparam int RESULT_W     = 32;
  // Result scale: 0.01 % units, 100 % = 10000
  localparam logic [63:0] POWER_SCALE = 64'h0000_0000_0000_2710;
  localparam logic [63:0] AMP_SCALE   = 64'h0000_0000_05f5_e100;
  localparam logic [6:0]  RELEASE_PCT = 7'h61;  // 97 percent
  localparam logic [6:0]  FULL_PCT    = 7'h64;  // 100 percent
  // Timing: definite-time delay counts 5 ms steps of a 5 ns clock
  localparam int CLK_PERIOD_PS = 5000;
  localparam int STEP_TIME_US  = 5000;
  // Divide first: the plain product would overflow 32 bits
  localparam int STEP_CYCLES   = STEP_TIME_US * (1000000 / CLK_PERIOD_PS);
  localparam int DIV_STEPS     = 64;
  localparam int SQRT_STEPS    = 32;
  // Register byte offsets
  localparam logic [7:0] CTRL_OFS     = 8'h00;
  localparam logic [7:0] THRESH_OFS   = 8'h04;
  localparam logic [7:0] DELAY_OFS    = 8'h08;
  localparam logic [7:0] STATUS_OFS   = 8'h0c;
  localparam logic [7:0] INT_STAT_OFS = 8'h10;
  localparam logic [7:0] INT_MASK_OFS = 8'h14;
  localparam logic [7:0] RESULT1_OFS  = 8'h18;
  localparam logic [7:0] RESULT2_OFS  = 8'h1c;
  localparam logic [7:0] RESULT3_OFS  = 8'h20;
  // CTRL fields
  localparam int CTRL_MODE_LSB = 0;
  localparam int CTRL_METHOD   = 3;  // 0 amplitude ratio, 1 power ratio
  localparam int CTRL_ALM_EN   = 4;
  // Interrupt status bits
  localparam int EV_START   = 0;
  localparam int EV_ALARM   = 1;
  localparam int EV_BLOCKED = 2;
  localparam int EV_DONE    = 3;
  localparam int EV_W       = 4;
  // Operating modes
  localparam logic [2:0] MODE_ON           = 3'h0;
  localparam logic [2:0] MODE_BLOCKED      = 3'h1;
  localparam logic [2:0] MODE_TEST         = 3'h2;
  localparam logic [2:0] MODE_TEST_BLOCKED = 3'h3;
  localparam logic [2:0] MODE_OFF          = 3'h4;
  // Reset values
  localparam logic [2:0]  MODE_RST    = MODE_ON;
  localparam logic        METHOD_RST  = 1'b0;
  localparam logic        ALM_EN_RST  = 1'b1;
  localparam logic [13:0] THRESH_RST  = 14'h03e8;  // 10.00 %
  localparam logic [18:0] DELAY_RST   = 19'h007d0; // 10.000 s
  typedef enum logic [2:0] {
    VDM_COLLECT, VDM_DIV, VDM_SQRT, VDM_EVAL, VDM_DECIDE
  } vdm_phase_t;
  typedef enum logic [1:0] {
    VDM_NORMAL, VDM_START, VDM_ALARM, VDM_BLOCKED
  } vdm_cond_t;
endpackage : vdm_pkg

// ==== verif/vdm_monitor_asserts.sv ====
// Port-level assertions for the voltage distortion monitor
module vdm_monitor_asserts #(
  parameter int STEP_CYCLES = 4
) (
  // Clock and reset
  input  wire logic        CLK_I,
  input  wire logic        SYS_RST_I,
  // Register port
  input  wire logic        WR_I,
  input  wire logic [7:0]  ADDR_I,
  input  wire logic [31:0] WR_DATA_I,
  input  wire logic        RD_I,
  input  wire logic [31:0] RD_DATA_O,
  // Spectrum stream
  input  wire logic        SPEC_VALID_I,
  input  wire logic        SPEC_FIRST_I,
  // System controls
  input  wire logic        INDIV_MODE_EN_I,
  // Status
  input  wire logic        BUSY_O,
  input  wire logic        START_O,
  input  wire logic        ALARM_O,
  input  wire logic        BLOCKED_O
);
  timeunit 1ns;
  timeprecision 100ps;
  default clocking cb @(posedge CLK_I); endclocking
  default disable iff (SYS_RST_I);
  logic [5:0] beat_reg;
  logic [5:0] beat_next;
  logic       last_beat;
  logic [2:0] mode_reg;
  logic [2:0] mode_next;
  logic       mode_off;
  // Shadow of the mode field: off mode drops every beat
  assign mode_next = (WR_I && ADDR_I == vdm_pkg::CTRL_OFS)
                     ? WR_DATA_I[vdm_pkg::CTRL_MODE_LSB +: 3] : mode_reg;
  assign mode_off  = INDIV_MODE_EN_I && mode_reg == vdm_pkg::MODE_OFF;
  // Beats since a fundamental; a frame is only counted once it has begun
  assign last_beat = SPEC_VALID_I && !SPEC_FIRST_I && !BUSY_O && !mode_off
                     && beat_reg == 6'h1f;
  always_comb begin
    beat_next = beat_reg;
    if (BUSY_O || mode_off) begin
      beat_next = 6'h00;
    end else if (SPEC_VALID_I && SPEC_FIRST_I) begin
      beat_next = 6'h01;
    end else if (SPEC_VALID_I && beat_reg != 6'h00) begin
      beat_next = beat_reg + 6'h01;
    end
  end
  always_ff @(posedge CLK_I) begin
    beat_reg <= SYS_RST_I ? 6'h00 : beat_next;
    mode_reg <= SYS_RST_I ? vdm_pkg::MODE_RST : mode_next;
  end
  a_rd_idle_zero: assert property (!RD_I |=> RD_DATA_O == 32'h0)
    else $error("read data not zero outside read slot");
  a_reset_quiet: assert property (disable iff (1'b0)
    SYS_RST_I |=> !(BUSY_O || START_O || ALARM_O || BLOCKED_O))
    else $error("status output high after reset");
  a_busy_after_frame: assert property (last_beat |=> BUSY_O)
    else $error("busy missing after last beat");
  a_busy_not_early: assert property (!BUSY_O && !last_beat |=> !BUSY_O)
    else $error("busy before a full frame");
  a_calc_bounded: assert property ($rose(BUSY_O) |-> ##[1:600] !BUSY_O)
    else $error("calculation did not finish");
  a_alarm_with_start: assert property (ALARM_O |-> START_O)
    else $error("alarm without start");
  a_blocked_no_start: assert property (BLOCKED_O |-> !START_O)
    else $error("blocked and start together");
  a_alarm_after_start: assert property ($rose(ALARM_O) |-> $past(START_O))
    else $error("alarm not preceded by start");
  a_blocked_at_end: assert property ($rose(BLOCKED_O) |->
    $past(BUSY_O, 1) || $past(BUSY_O, 2))
    else $error("blocked outside a decision");
endmodule : vdm_monitor_asserts

// ==== verif/vdm_spec_src.sv ====
// Spectrum source standing in for the upstream measurement stage
module vdm_spec_src (
  // Clock and control
  input  wire logic        clk_i,
  input  wire logic        go_i,
  input  wire logic        gap_i,
  // Spectrum content
  input  wire logic [15:0] fund_i,
  input  wire logic [15:0] h1_i,
  input  wire logic [15:0] h2_i,
  input  wire logic [15:0] h3_i,
  // Stream
  output logic             valid_o,
  output logic             first_o,
  output logic [15:0]      ch1_o,
  output logic [15:0]      ch2_o,
  output logic [15:0]      ch3_o
);
  timeunit 1ns;
  timeprecision 100ps;
  // Content only on beats 2..10 keeps the expected results exact
  function automatic logic [15:0] comp(input int k, input logic [15:0] h);
    return (k == 0) ? fund_i : (k >= 2 && k <= 10) ? h : 16'h0000;
  endfunction : comp
  // Idle lines toggle so a stale value never looks like data
  task automatic idle();
    valid_o <= 1'b0;
    first_o <= 1'b0;
    ch1_o   <= ~ch1_o;
    ch2_o   <= ~ch2_o;
    ch3_o   <= ~ch3_o;
  endtask : idle
  initial begin
    {valid_o, first_o, ch1_o, ch2_o, ch3_o} = '0;
    forever begin
      @(posedge clk_i);
      if (go_i) begin
        for (int k = 0; k < 32; k++) begin
          valid_o <= 1'b1;
          first_o <= (k == 0);
          ch1_o   <= comp(k, h1_i);
          ch2_o   <= comp(k, h2_i);
          ch3_o   <= comp(k, h3_i);
          @(posedge clk_i);
          if (gap_i) begin
            idle();
            @(posedge clk_i);
          end
        end
      end
      idle();
    end
  end
endmodule : vdm_spec_src

// ==== verif/tb_top.sv ====
// Self-checking testbench of the voltage distortion monitor
module tb_top;
  timeunit 1ns;
  timeprecision 100ps;
  logic        clk, sys_rst, wr, rd, spec_valid, spec_first, block, indiv;
  logic        busy, start, alarm, blocked, irq, go, gap;
  logic [7:0]  addr;
  logic [31:0] wr_data, rd_data;
  logic [15:0] ch1, ch2, ch3, h1, h2;
  int          num_errors, checked;
  // {block, dirty, start, blocked}
  logic [3:0]  blk_tab [4] = '{4'b1101, 4'b0000, 4'b0110, 4'b1100};
  // {ctrl[4:0], indiv, start, blocked}
  logic [7:0]  mode_tab [7] = '{8'h86, 8'h8d, 8'h94, 8'h9d, 8'ha4, 8'h8a,
                                8'h04};
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  vdm_voltage_distortion_monitor #(.STEP_CYCLES(4)) u_dut (
    .CLK_I(clk), .SYS_RST_I(sys_rst), .ADDR_I(addr), .WR_DATA_I(wr_data),
    .WR_I(wr), .RD_I(rd), .RD_DATA_O(rd_data), .SPEC_VALID_I(spec_valid),
    .SPEC_FIRST_I(spec_first), .SPEC_CH1_I(ch1), .SPEC_CH2_I(ch2),
    .SPEC_CH3_I(ch3), .BLOCK_I(block), .INDIV_MODE_EN_I(indiv),
    .BUSY_O(busy), .START_O(start), .ALARM_O(alarm), .BLOCKED_O(blocked),
    .IRQ_O(irq));
  vdm_spec_src u_src (
    .clk_i(clk), .go_i(go), .gap_i(gap), .fund_i(16'h03e8), .h1_i(h1),
    .h2_i(h2), .h3_i(16'h0014), .valid_o(spec_valid), .first_o(spec_first),
    .ch1_o(ch1), .ch2_o(ch2), .ch3_o(ch3));
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      num_errors++;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    addr    <= a;
    wr_data <= d;
    wr      <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask : wr_reg
  task automatic rd_reg(input logic [7:0] a, input logic [31:0] exp);
    @(posedge clk);
    addr <= a;
    rd   <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1;
    chk(rd_data, exp);
  endtask : rd_reg
  task automatic wait_busy(input logic want);
    int n;
    n = 0;
    while (busy !== want && n < 2000) begin
      @(posedge clk);
      #1;
      n++;
    end
    chk({31'h0, busy}, {31'h0, want});
  endtask : wait_busy
  // Off mode computes nothing, so busy is not awaited there
  task automatic frame(input logic [15:0] a, input logic [15:0] b,
                       input logic g, input logic w);
    @(posedge clk);
    h1  <= a;
    h2  <= b;
    gap <= g;
    go  <= 1'b1;
    @(posedge clk);
    go <= 1'b0;
    if (w) begin
      wait_busy(1'b1);
      wait_busy(1'b0);
    end else begin
      repeat (400) @(posedge clk);
    end
    @(posedge clk);
    #1;
  endtask : frame
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", checked, num_errors);
    if (num_errors == 0 && checked > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : report_and_stop
  initial begin
    #100_000;
    num_errors++;
    $display("[FAIL] %0t watchdog expired", $time);
    report_and_stop();
  end
  initial begin
    {addr, wr_data, wr, rd, block, go, gap, h1, h2} = '0;
    indiv      = 1'b1;
    sys_rst    = 1'b1;
    num_errors = 0;
    checked    = 0;
    repeat (6) @(posedge clk);
    sys_rst <= 1'b0;
    wr_reg(8'hfc, 32'hffff_ffff);
    rd_reg(vdm_pkg::CTRL_OFS, 32'h0000_0010);
    rd_reg(vdm_pkg::THRESH_OFS, 32'h0000_03e8);
    rd_reg(vdm_pkg::DELAY_OFS, 32'h0000_07d0);
    rd_reg(8'hfc, 32'h0000_0000);
    $display("test 1 done");
    wr_reg(vdm_pkg::DELAY_OFS, 32'h0000_0003);
    wr_reg(vdm_pkg::INT_MASK_OFS, 32'h0000_0008);
    frame(16'h0064, 16'h000a, 1'b1, 1'b1);
    chk({31'h0, start}, 32'h1);
    chk({31'h0, alarm}, 32'h0);
    rd_reg(vdm_pkg::STATUS_OFS, 32'h0000_0005);
    rd_reg(vdm_pkg::RESULT1_OFS, 32'h0000_0bb8);
    rd_reg(vdm_pkg::RESULT2_OFS, 32'h0000_012c);
    rd_reg(vdm_pkg::RESULT3_OFS, 32'h0000_0258);
    chk({31'h0, irq}, 32'h1);
    repeat (40) @(posedge clk);
    chk({31'h0, alarm}, 32'h1);
    rd_reg(vdm_pkg::INT_STAT_OFS, 32'h0000_000b);
    wr_reg(vdm_pkg::INT_MASK_OFS, 32'h0000_0000);
    @(posedge clk);
    #1;
    chk({31'h0, irq}, 32'h0);
    wr_reg(vdm_pkg::INT_STAT_OFS, 32'h0000_000f);
    rd_reg(vdm_pkg::INT_STAT_OFS, 32'h0000_0000);
    $display("test 2 done");
    wr_reg(vdm_pkg::CTRL_OFS, 32'h0000_0018);
    wr_reg(vdm_pkg::THRESH_OFS, 32'h0000_0398);
    frame(16'h0064, 16'h000a, 1'b0, 1'b1);
    rd_reg(vdm_pkg::RESULT1_OFS, 32'h0000_0384);
    rd_reg(vdm_pkg::RESULT2_OFS, 32'h0000_0009);
    rd_reg(vdm_pkg::RESULT3_OFS, 32'h0000_0024);
    chk({31'h0, alarm}, 32'h1);
    wr_reg(vdm_pkg::THRESH_OFS, 32'h0000_03a2);
    frame(16'h0064, 16'h000a, 1'b0, 1'b1);
    chk({30'h0, start, alarm}, 32'h0);
    $display("test 3 done");
    wr_reg(vdm_pkg::CTRL_OFS, 32'h0000_0010);
    wr_reg(vdm_pkg::THRESH_OFS, 32'h0000_03e8);
    wr_reg(vdm_pkg::DELAY_OFS, 32'h0000_07d0);
    for (int i = 0; i < 4; i++) begin
      @(posedge clk);
      block <= blk_tab[i][3];
      frame(blk_tab[i][2] ? 16'h0064 : 16'h0000, 16'h0000, 1'b0, 1'b1);
      chk({30'h0, start, blocked}, {30'h0, blk_tab[i][1:0]});
    end
    @(posedge clk);
    block <= 1'b0;
    $display("test 4 done");
    for (int i = 0; i < 7; i++) begin
      wr_reg(vdm_pkg::CTRL_OFS, 32'h0000_0010);
      frame(16'h0000, 16'h0000, 1'b0, 1'b1);
      wr_reg(vdm_pkg::CTRL_OFS, {27'h0, mode_tab[i][7:3]});
      @(posedge clk);
      indiv <= mode_tab[i][2];
      frame(16'h0064, 16'h0000, 1'b1, mode_tab[i][7:3] != 5'h14);
      chk({30'h0, start, blocked}, {30'h0, mode_tab[i][1:0]});
      @(posedge clk);
      indiv <= 1'b1;
    end
    $display("test 5 done");
    report_and_stop();
  end
endmodule : tb_top
bind vdm_voltage_distortion_monitor vdm_monitor_asserts #(
  .STEP_CYCLES(STEP_CYCLES)
) u_chk (
  .CLK_I(CLK_I), .SYS_RST_I(SYS_RST_I), .RD_I(RD_I), .RD_DATA_O(RD_DATA_O),
  .WR_I(WR_I), .ADDR_I(ADDR_I), .WR_DATA_I(WR_DATA_I),
  .INDIV_MODE_EN_I(INDIV_MODE_EN_I),
  .SPEC_VALID_I(SPEC_VALID_I), .SPEC_FIRST_I(SPEC_FIRST_I), .BUSY_O(BUSY_O),
  .START_O(START_O), .ALARM_O(ALARM_O), .BLOCKED_O(BLOCKED_O));
